/* File: core/astc_defines.svh */
`ifndef ASTC_DEFINES_SVH
`define ASTC_DEFINES_SVH
// register byte addresses
`define ASTC_ADDR_CTRL     8'h00
`define ASTC_ADDR_CMD      8'h04
`define ASTC_ADDR_EXPO     8'h08
`define ASTC_ADDR_PACE     8'h0C
`define ASTC_ADDR_STATUS   8'h10
// control fields
`define ASTC_CTRL_MODE_ON  0
`define ASTC_CTRL_ORG_LO   1
`define ASTC_CTRL_ORG_HI   2
`define ASTC_CTRL_EDGE     3
`define ASTC_CTRL_TARGET   4
`define ASTC_CTRL_EXPMODE  5
`define ASTC_CTRL_PACE_EN  6
`define ASTC_CTRL_RUNMODE  7
`define ASTC_CTRL_RESET    32'h0000_0012
// origin encodings
`define ASTC_ORG_SW        2'h0
`define ASTC_ORG_LINE1     2'h1
`define ASTC_ORG_LINE2     2'h2
// command bits
`define ASTC_CMD_TRIG      0
`define ASTC_CMD_START     1
`define ASTC_CMD_STOP      2
// reset values
`define ASTC_EXPO_RESET    32'h0000_0064
`define ASTC_PACE_RESET    32'h0000_03E8
`define ASTC_ZERO32        32'h0000_0000
`define ASTC_ONE32         32'h0000_0001
`define ASTC_ONE16         16'h0001
`endif

/* File: core/astc_pkg.sv */
package astc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_EXPOSE,
    ST_READOUT
  } astc_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
    logic level;
  } astc_sync_t;

  typedef struct packed {
    astc_state_t st;
    logic [31:0] ctrl;
    logic [31:0] expo;
    logic [31:0] pace;
    logic [31:0] cnt;
    logic [31:0] pace_cnt;
    logic [15:0] discards;
    logic [31:0] rdata;
    logic        frame_start;
    logic        waiting;
    logic        exposing;
    logic        width;
    logic        stop_pend;
  } astc_core_t;
endpackage : astc_pkg

/* File: core/astc_edge_sync.sv */
`timescale 1ns/1ps
module astc_edge_sync (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic line_in,
  input  wire logic fall_sel,
  output logic      edge_pulse,
  output logic      active_level
);
  astc_pkg::astc_sync_t q;
  astc_pkg::astc_sync_t d;

  // two-stage sync, then edge detect between second and third stages
  always_comb begin
    d       = q;
    d.s1    = line_in;
    d.s2    = q.s1;
    d.s3    = q.s2;
    d.pulse = fall_sel ? (q.s3 & ~q.s2) : (q.s2 & ~q.s3);
    d.level = q.s2 ^ fall_sel;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign edge_pulse   = q.pulse;
  assign active_level = q.level;

  chk_one_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
    q.pulse |=> !q.pulse) else $error("edge pulse longer than one cycle");
endmodule : astc_edge_sync

/* File: core/astc_top.sv */
// Contract
// - trigger source selects software command, input line 1 or input line 2.
// - with software source each host trigger command is one start trigger.
// - with a line source the trigger comes from that input line.
// - rising edge activation makes low-to-high line transition the trigger.
// - falling edge activation makes high-to-low line transition the trigger.
// - after reset the trigger source is input line 1.
// - triggers act only while waiting for start trigger; otherwise ignored.
// - software source exposure length comes from the exposure value.
// - line source exposure from exposure value or from trigger pulse width.
// - software trigger while waiting begins a new frame exposure.
// - exposure start leaves waiting; waiting returns once a trigger is acceptable.
// - software triggers arriving while not ready are discarded.
// - host trigger command reaches start trigger only when target selects it.
// - pacing enable paces internally generated acquisitions at the pacing value while trigger mode is off.
// - with trigger mode off, start triggers are generated internally.
`timescale 1ns/1ps
`include "astc_defines.svh"
module astc_top #(
  parameter int          READOUT_CYCLES = 16,
  parameter logic [31:0] READOUT_LEN    = 32'(READOUT_CYCLES)
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        trig_line1,
  input  wire logic        trig_line2,
  output logic             frame_start,
  output logic             exposure_active,
  output logic             waiting_for_trigger
);
  astc_pkg::astc_core_t q;
  astc_pkg::astc_core_t d;

  logic       line1_pulse;
  logic       line1_level;
  logic       line2_pulse;
  logic       line2_level;
  logic       trig_mode_on;
  logic [1:0] trigger_origin_select;
  logic       trigger_edge_select;
  logic       trigger_target_select;
  logic       exposure_duration_mode;
  logic       internal_pacing_enable;
  logic       capture_run_mode;
  logic       cmd_wr;
  logic       host_trigger_command;
  logic       acq_start_cmd;
  logic       acq_stop_cmd;
  logic       sw_trig;
  logic       line_trig;
  logic       pace_tick;
  logic       int_trig;
  logic       any_trig;
  logic       sel_level;
  logic       width_sel;

  // line 1 and line 2 synchronisers with edge detect
  astc_edge_sync u_line1 (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .line_in      (trig_line1),
    .fall_sel     (trigger_edge_select),
    .edge_pulse   (line1_pulse),
    .active_level (line1_level)
  );

  astc_edge_sync u_line2 (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .line_in      (trig_line2),
    .fall_sel     (trigger_edge_select),
    .edge_pulse   (line2_pulse),
    .active_level (line2_level)
  );

  // control field decode
  assign trig_mode_on           = q.ctrl[`ASTC_CTRL_MODE_ON];
  assign trigger_origin_select  = q.ctrl[`ASTC_CTRL_ORG_HI:`ASTC_CTRL_ORG_LO];
  assign trigger_edge_select    = q.ctrl[`ASTC_CTRL_EDGE];
  assign trigger_target_select  = q.ctrl[`ASTC_CTRL_TARGET];
  assign exposure_duration_mode = q.ctrl[`ASTC_CTRL_EXPMODE];
  assign internal_pacing_enable = q.ctrl[`ASTC_CTRL_PACE_EN];
  assign capture_run_mode       = q.ctrl[`ASTC_CTRL_RUNMODE];

  assign cmd_wr               = reg_wr && (reg_addr == `ASTC_ADDR_CMD);
  assign host_trigger_command = cmd_wr && reg_wdata[`ASTC_CMD_TRIG];
  assign acq_start_cmd        = cmd_wr && reg_wdata[`ASTC_CMD_START];
  assign acq_stop_cmd         = cmd_wr && reg_wdata[`ASTC_CMD_STOP];

  // trigger sources
  assign sw_trig = trig_mode_on && (trigger_origin_select == `ASTC_ORG_SW)
                   && trigger_target_select && host_trigger_command;
  assign line_trig = trig_mode_on
                     && (((trigger_origin_select == `ASTC_ORG_LINE1) && line1_pulse)
                      || ((trigger_origin_select == `ASTC_ORG_LINE2) && line2_pulse));
  assign pace_tick = (q.pace_cnt == `ASTC_ZERO32);
  assign int_trig  = !trig_mode_on && (q.st == astc_pkg::ST_WAIT)
                     && (!internal_pacing_enable || pace_tick);
  assign any_trig  = sw_trig || line_trig || int_trig;
  assign sel_level = (trigger_origin_select == `ASTC_ORG_LINE2) ? line2_level : line1_level;
  assign width_sel = trig_mode_on && (trigger_origin_select != `ASTC_ORG_SW)
                     && exposure_duration_mode;

  always_comb begin
    d             = q;
    d.frame_start = 1'b0;
    d.rdata       = `ASTC_ZERO32;
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `ASTC_ADDR_CTRL: d.ctrl = reg_wdata;
        `ASTC_ADDR_EXPO: d.expo = reg_wdata;
        `ASTC_ADDR_PACE: d.pace = reg_wdata;
        default: ;
      endcase
    end
    // register reads, data in next cycle only
    if (reg_rd) begin
      unique case (reg_addr)
        `ASTC_ADDR_CTRL:   d.rdata = q.ctrl;
        `ASTC_ADDR_EXPO:   d.rdata = q.expo;
        `ASTC_ADDR_PACE:   d.rdata = q.pace;
        `ASTC_ADDR_STATUS: d.rdata = {q.discards, 12'h000, q.stop_pend,
                                      q.st == astc_pkg::ST_READOUT, q.exposing, q.waiting};
        default:           d.rdata = `ASTC_ZERO32;
      endcase
    end
    // internal pacing counter
    if (q.st == astc_pkg::ST_IDLE) begin
      d.pace_cnt = `ASTC_ZERO32;
    end else if (pace_tick) begin
      if (int_trig) begin
        d.pace_cnt = q.pace - `ASTC_ONE32;
      end
    end else begin
      d.pace_cnt = q.pace_cnt - `ASTC_ONE32;
    end
    // triggers outside waiting are dropped and counted
    if ((sw_trig || line_trig) && (q.st != astc_pkg::ST_WAIT)) begin
      d.discards = q.discards + `ASTC_ONE16;
    end
    unique case (q.st)
      astc_pkg::ST_IDLE: begin
        if (acq_start_cmd) begin
          d.st        = astc_pkg::ST_WAIT;
          d.stop_pend = 1'b0;
        end
      end
      astc_pkg::ST_WAIT: begin
        if (acq_stop_cmd) begin
          d.st = astc_pkg::ST_IDLE;
        end else if (any_trig) begin
          d.st          = astc_pkg::ST_EXPOSE;
          d.frame_start = 1'b1;
          d.cnt         = q.expo;
          d.width       = width_sel;
        end
      end
      astc_pkg::ST_EXPOSE: begin
        if (acq_stop_cmd) begin
          d.stop_pend = 1'b1;
        end
        if (q.width ? !sel_level : (q.cnt <= `ASTC_ONE32)) begin
          d.st  = astc_pkg::ST_READOUT;
          d.cnt = READOUT_LEN;
        end else begin
          d.cnt = q.width ? q.cnt : q.cnt - `ASTC_ONE32;
        end
      end
      astc_pkg::ST_READOUT: begin
        if (acq_stop_cmd) begin
          d.stop_pend = 1'b1;
        end
        if (q.cnt <= `ASTC_ONE32) begin
          if (capture_run_mode && !q.stop_pend && !acq_stop_cmd) begin
            d.st = astc_pkg::ST_WAIT;
          end else begin
            d.st = astc_pkg::ST_IDLE;
          end
        end else begin
          d.cnt = q.cnt - `ASTC_ONE32;
        end
      end
    endcase
    d.waiting  = (d.st == astc_pkg::ST_WAIT);
    d.exposing = (d.st == astc_pkg::ST_EXPOSE);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q          <= '0;
      q.st       <= astc_pkg::ST_IDLE;
      q.ctrl     <= `ASTC_CTRL_RESET;
      q.expo     <= `ASTC_EXPO_RESET;
      q.pace     <= `ASTC_PACE_RESET;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata           = q.rdata;
  assign frame_start         = q.frame_start;
  assign exposure_active     = q.exposing;
  assign waiting_for_trigger = q.waiting;

  sequence s_wait_sw;
    (q.st == astc_pkg::ST_WAIT) && sw_trig && !acq_stop_cmd;
  endsequence

  sequence s_expose_begin;
    q.frame_start && q.exposing && !q.waiting;
  endsequence

  chk_sw_starts_frame: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_wait_sw |=> s_expose_begin) else $error("software trigger did not start exposure");

  chk_start_needs_wait: assert property (@(posedge core_clk) disable iff (!arst_n)
    q.frame_start |-> $past(q.st) == astc_pkg::ST_WAIT) else $error("frame began outside waiting");

  chk_sw_discard: assert property (@(posedge core_clk) disable iff (!arst_n)
    (sw_trig && (q.st != astc_pkg::ST_WAIT)) |=> !q.frame_start && (q.discards == $past(q.discards) + 16'h0001))
    else $error("busy software trigger not discarded");

  chk_target_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
    (host_trigger_command && !trigger_target_select && trig_mode_on) |=> !q.frame_start)
    else $error("trigger routed without target select");

  chk_line_start: assert property (@(posedge core_clk) disable iff (!arst_n)
    ((q.st == astc_pkg::ST_WAIT) && line_trig && !acq_stop_cmd) |=> s_expose_begin)
    else $error("line edge did not start exposure");

  chk_internal_gen: assert property (@(posedge core_clk) disable iff (!arst_n)
    ((q.st == astc_pkg::ST_WAIT) && !trig_mode_on && !internal_pacing_enable && !acq_stop_cmd)
    |=> q.frame_start) else $error("internal trigger not generated");

  chk_no_self_start: assert property (@(posedge core_clk) disable iff (!arst_n)
    (trig_mode_on && !sw_trig && !line_trig) |=> !q.frame_start) else $error("frame began on its own");

  chk_timed_length: assert property (@(posedge core_clk) disable iff (!arst_n)
    (q.frame_start && !q.width && (q.expo == 32'h0000_0004) && $stable(q.expo))
    |-> q.exposing [*4] ##1 !q.exposing) else $error("timed exposure length wrong");

  chk_width_end: assert property (@(posedge core_clk) disable iff (!arst_n)
    ((q.st == astc_pkg::ST_EXPOSE) && q.width && !sel_level) |=> (q.st == astc_pkg::ST_READOUT))
    else $error("width exposure did not end with pulse");

  chk_rewait: assert property (@(posedge core_clk) disable iff (!arst_n)
    ((q.st == astc_pkg::ST_READOUT) && (q.cnt <= 32'h0000_0001) && capture_run_mode
     && !q.stop_pend && !acq_stop_cmd) |=> q.waiting) else $error("waiting not re-entered");

  chk_leave_wait: assert property (@(posedge core_clk) disable iff (!arst_n)
    q.frame_start |-> !q.waiting ##1 !q.waiting) else $error("still waiting after start");
endmodule : astc_top

/* File: verification/astc_line_src.sv */
`timescale 1ns/1ps
module astc_line_src (
  input  wire logic core_clk,
  output logic      line1,
  output logic      line2
);
  initial begin
    line1 = 1'b0;
    line2 = 1'b0;
  end
  // one edge per wanted frame, moved just after a clock edge
  task automatic drive(input int which, input logic lvl);
    @(posedge core_clk);
    if (which == 1) begin
      line1 <= lvl;
    end else begin
      line2 <= lvl;
    end
  endtask : drive
endmodule : astc_line_src

/* File: verification/acquisition_start_trigger_ctrl_bench.sv */
`timescale 1ns/1ps
`include "astc_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; $display("FAIL t=%0t got %0h exp %0h", $time, (a), (b)); end end
module acquisition_start_trigger_ctrl_bench;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] e;
  } astc_row_t;
  logic        core_clk;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        trig_line1;
  logic        trig_line2;
  logic        frame_start;
  logic        exposure_active;
  logic        waiting_for_trigger;
  int          err_total = 0;
  int          num_checks = 0;
  int          n;
  int          expo_cnt = 0;
  int          last_len = 0;
  logic [31:0] d;
  astc_row_t   rows [6];

  astc_top #(.READOUT_CYCLES(2)) u_dut (.*);
  astc_line_src u_src (.core_clk(core_clk), .line1(trig_line1), .line2(trig_line2));

  // length of the last exposure in cycles
  always @(posedge core_clk) begin
    expo_cnt <= (exposure_active === 1'b1) ? expo_cnt + 1 : 0;
    if (exposure_active === 1'b0 && expo_cnt != 0) begin
      last_len <= expo_cnt;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  // which 0 frame start, 1 waiting; bounded at 60 cycles
  task automatic wait_on(input int which, output int cnt);
    cnt = 0;
    do begin
      @(posedge core_clk);
      #1;
      cnt++;
    end while (((which == 0) ? frame_start : waiting_for_trigger) !== 1'b1 && cnt < 60);
  endtask : wait_on

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #50000;
    err_total++;
    $display("FAIL t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    arst_n    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    rows = '{'{`ASTC_ADDR_CTRL, `ASTC_CTRL_RESET}, '{`ASTC_ADDR_EXPO, `ASTC_EXPO_RESET},
             '{`ASTC_ADDR_PACE, `ASTC_PACE_RESET}, '{`ASTC_ADDR_STATUS, `ASTC_ZERO32},
             '{`ASTC_ADDR_CMD, `ASTC_ZERO32}, '{8'h20, `ASTC_ZERO32}};
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    wr(8'h20, 32'hFFFF_FFFF);
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      `CHK(d, rows[i].e);
    end
    $display("test reset values done");
    // software source, continuous, timed
    wr(`ASTC_ADDR_EXPO, 32'h0000_0004);
    wr(`ASTC_ADDR_CTRL, 32'h0000_0091);
    wr(`ASTC_ADDR_CMD, 32'h0000_0002);
    wait_on(1, n);
    `CHK(waiting_for_trigger, 1'b1);
    wr(`ASTC_ADDR_CMD, 32'h0000_0001);
    #1;
    `CHK(frame_start, 1'b1);
    `CHK(waiting_for_trigger, 1'b0);
    wait_on(1, n);
    `CHK(last_len, 4);
    `CHK(waiting_for_trigger, 1'b1);
    wr(`ASTC_ADDR_CMD, 32'h0000_0001);
    wr(`ASTC_ADDR_CMD, 32'h0000_0001);
    rd(`ASTC_ADDR_STATUS, d);
    `CHK(d[31:16], 16'h0001);
    $display("test software trigger done");
    wait_on(1, n);
    wr(`ASTC_ADDR_CTRL, 32'h0000_0081);
    wr(`ASTC_ADDR_CMD, 32'h0000_0001);
    #1;
    `CHK(frame_start, 1'b0);
    wait_on(0, n);
    `CHK(frame_start, 1'b0);
    $display("test target select done");
    wr(`ASTC_ADDR_CTRL, 32'h0000_0093);
    u_src.drive(1, 1'b1);
    wait_on(0, n);
    `CHK(n, 4);
    wait_on(1, n);
    u_src.drive(1, 1'b0);
    wait_on(0, n);
    `CHK(frame_start, 1'b0);
    u_src.drive(2, 1'b1);
    wr(`ASTC_ADDR_CTRL, 32'h0000_009D);
    u_src.drive(1, 1'b1);
    wait_on(0, n);
    `CHK(frame_start, 1'b0);
    u_src.drive(2, 1'b0);
    wait_on(0, n);
    `CHK(n, 4);
    wait_on(1, n);
    $display("test line edges done");
    u_src.drive(1, 1'b0);
    wr(`ASTC_ADDR_CTRL, 32'h0000_00B3);
    u_src.drive(1, 1'b1);
    repeat (9) @(posedge core_clk);
    u_src.drive(1, 1'b0);
    wait_on(1, n);
    `CHK((last_len >= 9) && (last_len <= 11), 1'b1);
    $display("test trigger width done");
    wr(`ASTC_ADDR_CMD, 32'h0000_0004);
    wr(`ASTC_ADDR_PACE, 32'h0000_001E);
    wr(`ASTC_ADDR_CTRL, 32'h0000_00D0);
    wr(`ASTC_ADDR_CMD, 32'h0000_0002);
    wait_on(0, n);
    `CHK(frame_start, 1'b1);
    wait_on(0, n);
    `CHK((n >= 30) && (n <= 32), 1'b1);
    wr(`ASTC_ADDR_CMD, 32'h0000_0004);
    repeat (12) @(posedge core_clk);
    wait_on(0, n);
    `CHK(frame_start, 1'b0);
    $display("test internal pacing done");
    conclude();
  end
endmodule : acquisition_start_trigger_ctrl_bench
